// ---- trf_result_formatter.sv ----
/*
  Temperature result formatter: corrects, encodes and publishes results of
  remote one, local and remote two channels, with limits and read freeze.
  Assumes a front end delivering raw results with a one-cycle valid, and a
  classic Wishbone master on the register side.
*/
// Notes on behaviour
// - Results are 10 bits at quarter degree; high byte per channel, low pair shared.
// - Two's complement fault reads as 1000 0000, minus 128 degrees.
// - Extended range stores temperature plus 64, unsigned; 0 degrees is 0x40.
// - Extended range fault reads as all zeros, minus 64 degrees.
// - Channel offset, signed 8 bits, is added to every measurement.
// - Config bit picks 1 degree or half degree offset steps.
// - Three offset registers, one per channel, each reset to zero.
// - Compatibility bit stores values in two's complement, minus 63 to 127.
// - In compatibility mode values below minus 63 clamp to minus 63.
// - Low bits: remote two at 7:6, local at 5:4, remote one at 3:2.
// - Channel status bit set when value breaks its high or low limit.
// - Alert asserts only when unmasked and alert pin configured as output.
// - Low limits reset to 0x81, high limits to 0x7f.
// - Reading the low-bit register freezes value registers until all are read.
// - 8-bit values are readable any time, any order.
// - Value registers sit at 0x25, 0x26, 0x27 for remote one, local, remote two.
// - High flag on strictly greater; low flag on less or equal.
`timescale 1ns/1ps
`default_nettype none
`include "trf_map.svh"

module trf_result_formatter (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Wishbone slave
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Measurements, channel 0 remote one, 1 local, 2 remote two
  input  wire logic [9:0]  meas_remote_one,
  input  wire logic [9:0]  meas_local,
  input  wire logic [9:0]  meas_remote_two,
  input  wire logic [2:0]  meas_fault,
  input  wire logic [2:0]  meas_valid,
  // Status and alert
  output logic [2:0]       temp_high_status,
  output logic [2:0]       temp_low_status,
  output logic             alert_n
);

  localparam int NCH = 3;

  // Software state
  logic [7:0]              low_limit  [NCH];
  logic [7:0]              high_limit [NCH];
  logic [7:0]              offset     [NCH];
  logic [7:0]              config_reg;
  logic [7:0]              mask_reg;

  // Result state
  trf_pkg::trf_result_t    shadow     [NCH];
  logic [7:0]              value      [NCH];
  logic [1:0]              low_bits   [NCH];
  trf_pkg::trf_freeze_t    freeze_state;
  trf_pkg::trf_freeze_t    next_freeze_state;
  logic [2:0]              read_seen;
  logic [2:0]              next_read_seen;

  // Per channel wires
  wire logic [9:0]         raw        [NCH];
  trf_pkg::trf_result_t    formatted  [NCH];
  wire logic [2:0]         over_high;
  wire logic [2:0]         at_low;
  wire logic [2:0]         sel_value;
  wire logic [2:0]         sel_low;
  wire logic [2:0]         sel_high;
  wire logic [2:0]         sel_offset;
  wire logic [7:0]         value_rd   [NCH];
  wire logic [7:0]         low_rd     [NCH];
  wire logic [7:0]         high_rd    [NCH];
  wire logic [7:0]         offset_rd  [NCH];

  // Bus decode
  wire logic [7:0]         idx;
  wire logic               access;
  wire logic               wr_en;
  wire logic               rd_en;
  wire logic               sel_low_bits;
  wire logic               sel_config;
  wire logic               sel_mask;
  wire logic               sel_status;
  wire logic               compat;
  wire logic               half_step;
  wire logic               alert_out_en;
  wire logic [7:0]         low_bits_rd;
  wire logic [7:0]         status_rd;
  wire logic [7:0]         read_byte;
  wire logic [2:0]         value_read;
  wire logic               frozen;
  wire logic               alert_cause;

  // Freeze, write strobe, read and alert helpers
  wire logic               low_bits_read;
  wire logic               hold_publish;
  wire logic [2:0]         seen_now;
  wire logic               all_seen;
  wire logic               wr_config;
  wire logic               wr_mask;
  wire logic [2:0]         wr_low;
  wire logic [2:0]         wr_high;
  wire logic [2:0]         wr_offset;
  wire logic [5:0]         flags;
  wire logic [5:0]         unmasked;
  wire logic [7:0]         chan_byte;
  wire logic [7:0]         misc_byte;

  // Channel order: 0 remote one, 1 local, 2 remote two
  assign raw[0] = meas_remote_one;
  assign raw[1] = meas_local;
  assign raw[2] = meas_remote_two;

  // Register index from the byte address; the two low address bits are unused
  assign idx    = wb_adr_i[9:2];
  // Take a request once; ack drops the cycle after it is given
  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en  = access & wb_we_i & wb_sel_i[0];
  assign rd_en  = access & ~wb_we_i;

  // Config fields that act on the datapath and the pin
  assign compat       = config_reg[`TRF_CFG_COMPAT];
  assign half_step    = config_reg[`TRF_CFG_HALF_STEP];
  assign alert_out_en = config_reg[`TRF_CFG_ALERT_OUT];

  // Selects of the shared registers
  assign sel_low_bits = (idx == `TRF_IDX_LOW_BITS);
  assign sel_config   = (idx == `TRF_IDX_CONFIG);
  assign sel_mask     = (idx == `TRF_IDX_MASK);
  assign sel_status   = (idx == `TRF_IDX_STATUS);

  assign frozen       = (freeze_state == trf_pkg::TRF_FROZEN);

  // A low-bit read also holds the published copy on its own edge; without
  // this a result landing on that edge would pair new high bytes with the
  // low bits just returned
  assign low_bits_read = rd_en & sel_low_bits;
  assign hold_publish  = frozen | low_bits_read;
  // Value reads collected since the low-bit read, this cycle's included
  assign seen_now      = read_seen | value_read;
  assign all_seen      = (seen_now == 3'b111);

  // Write strobes of the shared registers; writes need byte lane 0
  assign wr_config     = wr_en & sel_config;
  assign wr_mask       = wr_en & sel_mask;

  // Per channel: formatter, register decode, settings and published copy
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
      trf_formatter u_fmt (
        .raw        (raw[ch]),
        .fault      (meas_fault[ch]),
        .offset     (offset[ch]),
        .half_step  (half_step),
        .compat     (compat),
        .low_limit  (low_limit[ch]),
        .high_limit (high_limit[ch]),
        .result     (formatted[ch]),
        .over_high  (over_high[ch]),
        .at_low     (at_low[ch])
      );

      // Value and offset addresses are consecutive from each channel-0 index; limit addresses step by two
      assign sel_value[ch]  = (idx == 8'(`TRF_IDX_R1_VALUE + ch));
      assign sel_low[ch]    = (idx == 8'(`TRF_IDX_R1_LOW + 2 * ch));
      assign sel_high[ch]   = (idx == 8'(`TRF_IDX_R1_HIGH + 2 * ch));
      assign sel_offset[ch] = (idx == 8'(`TRF_IDX_R1_OFFSET + ch));
      assign value_read[ch] = rd_en & sel_value[ch];

      assign value_rd[ch]   = sel_value[ch] ? value[ch] : 8'h00;
      assign low_rd[ch]     = sel_low[ch] ? low_limit[ch] : 8'h00;
      assign high_rd[ch]    = sel_high[ch] ? high_limit[ch] : 8'h00;
      assign offset_rd[ch]  = sel_offset[ch] ? offset[ch] : 8'h00;

      // Write strobes of this channel's settings
      assign wr_low[ch]     = wr_en & sel_low[ch];
      assign wr_high[ch]    = wr_en & sel_high[ch];
      assign wr_offset[ch]  = wr_en & sel_offset[ch];

      // Settings written by software
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          low_limit[ch]  <= `TRF_RST_LOW_LIMIT;
          high_limit[ch] <= `TRF_RST_HIGH_LIMIT;
          offset[ch]     <= `TRF_RST_OFFSET;
        end else begin
          if (wr_low[ch]) begin
            low_limit[ch] <= wb_dat_i[7:0];
          end
          if (wr_high[ch]) begin
            high_limit[ch] <= wb_dat_i[7:0];
          end
          if (wr_offset[ch]) begin
            offset[ch] <= wb_dat_i[7:0];
          end
        end
      end

      // Latest formatted result and its limit flags; while frozen the
      // newest result waits here and publishes once the freeze ends
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          shadow[ch]           <= '0;
          temp_high_status[ch] <= 1'b0;
          temp_low_status[ch]  <= 1'b0;
        end else if (meas_valid[ch]) begin
          shadow[ch]           <= formatted[ch];
          temp_high_status[ch] <= over_high[ch];
          temp_low_status[ch]  <= at_low[ch];
        end
      end

      // Published copy, held while a coherent read is in progress
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          value[ch]    <= '0;
          low_bits[ch] <= '0;
        end else if (!hold_publish) begin
          value[ch]    <= shadow[ch][9:2];
          low_bits[ch] <= shadow[ch][1:0];
        end
      end

      assign low_bits_rd[`TRF_LOWBITS_BASE + 2 * ch +: 2] = low_bits[ch];
    end
  endgenerate

  assign low_bits_rd[1:0] = 2'b00;
  // Status reads back the live limit flags; they are levels, not sticky
  assign flags     = {temp_low_status, temp_high_status};
  assign status_rd = {2'b00, flags};

  // Read selection: at most one select is high, so the terms are ORed;
  // unmapped indices leave every term at zero
  assign chan_byte = value_rd[0] | value_rd[1] | value_rd[2]
                   | low_rd[0] | low_rd[1] | low_rd[2]
                   | high_rd[0] | high_rd[1] | high_rd[2]
                   | offset_rd[0] | offset_rd[1] | offset_rd[2];
  assign misc_byte = (sel_low_bits ? low_bits_rd : 8'h00)
                   | (sel_config ? config_reg : 8'h00)
                   | (sel_mask ? mask_reg : 8'h00)
                   | (sel_status ? status_rd : 8'h00);
  assign read_byte = chan_byte | misc_byte;

  // Freeze sequencing: low-bit read starts it, reading all values ends it
  always_comb begin
    next_freeze_state = freeze_state;
    next_read_seen    = read_seen;
    case (freeze_state)
      trf_pkg::TRF_LIVE: begin
        if (low_bits_read) begin
          next_freeze_state = trf_pkg::TRF_FROZEN;
          next_read_seen    = 3'b000;
        end
      end
      trf_pkg::TRF_FROZEN: begin
        // A second low-bit read starts the count again
        if (low_bits_read) begin
          next_read_seen = 3'b000;
        end else if (all_seen) begin
          next_freeze_state = trf_pkg::TRF_LIVE;
          next_read_seen    = 3'b000;
        end else begin
          next_read_seen = seen_now;
        end
      end
      default: begin
        next_freeze_state = trf_pkg::TRF_LIVE;
        next_read_seen    = 3'b000;
      end
    endcase
  end

  // Freeze state and the value reads seen so far
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      freeze_state <= trf_pkg::TRF_LIVE;
      read_seen    <= 3'b000;
    end else begin
      freeze_state <= next_freeze_state;
      read_seen    <= next_read_seen;
    end
  end

  // Config and mask registers; config bits above bit 2 are stored
  // but act on nothing
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      config_reg <= `TRF_RST_CONFIG;
      mask_reg   <= `TRF_RST_MASK;
    end else begin
      if (wr_config) begin
        config_reg <= wb_dat_i[7:0];
      end
      if (wr_mask) begin
        mask_reg <= wb_dat_i[7:0];
      end
    end
  end

  // Bus answer: ack one cycle after the request is taken, dropped the
  // cycle after; read data is loaded only by reads and then stands
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= access;
      if (rd_en) begin
        wb_dat_o <= {24'h000000, read_byte};
      end
    end
  end

  // Alert from unmasked limit flags when the pin acts as an output;
  // a set mask bit keeps its flag off the pin, and the pin comes from
  // a flop so flag updates cannot glitch it
  assign unmasked    = flags & ~mask_reg[5:0];
  assign alert_cause = alert_out_en & (|unmasked);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= ~alert_cause;
    end
  end

endmodule
`default_nettype wire

// ---- trf_map.svh ----
/*
  Register map, field positions, reset values and encoding constants of the
  temperature result formatter. Assumes inclusion by its bare name.
*/
`ifndef TRF_MAP_SVH
`define TRF_MAP_SVH

// Register indices; byte address on the bus is four times the index
`define TRF_IDX_R1_VALUE   8'h25
`define TRF_IDX_LOC_VALUE  8'h26
`define TRF_IDX_R2_VALUE   8'h27
`define TRF_IDX_R1_LOW     8'h4e
`define TRF_IDX_R1_HIGH    8'h4f
`define TRF_IDX_LOC_LOW    8'h50
`define TRF_IDX_LOC_HIGH   8'h51
`define TRF_IDX_R2_LOW     8'h52
`define TRF_IDX_R2_HIGH    8'h53
`define TRF_IDX_R1_OFFSET  8'h70
`define TRF_IDX_LOC_OFFSET 8'h71
`define TRF_IDX_R2_OFFSET  8'h72
`define TRF_IDX_LOW_BITS   8'h77
`define TRF_IDX_CONFIG     8'h7c
`define TRF_IDX_MASK       8'h7d
`define TRF_IDX_STATUS     8'h7e

// Reset values
`define TRF_RST_LOW_LIMIT  8'h81
`define TRF_RST_HIGH_LIMIT 8'h7f
`define TRF_RST_OFFSET     8'h00
`define TRF_RST_LOW_BITS   8'h00
`define TRF_RST_CONFIG     8'h00
`define TRF_RST_MASK       8'h00

// Config register fields
`define TRF_CFG_COMPAT     0
`define TRF_CFG_HALF_STEP  1
`define TRF_CFG_ALERT_OUT  2

// Status register fields: high flags in [2:0], low flags in [5:3]
`define TRF_STS_HIGH_LSB   0
`define TRF_STS_LOW_LSB    3

// Low-bit field position of channel n is 2 + 2*n
`define TRF_LOWBITS_BASE   2

// Result encodings in quarter degrees, 10 bits; the bias and the sum bounds are 12 bits
`define TRF_TWOS_FAULT     10'h200
`define TRF_TWOS_MIN       10'h304
`define TRF_TWOS_MAX       10'h1ff
`define TRF_EXT_FAULT      10'h000
`define TRF_EXT_MIN        10'h004
`define TRF_EXT_MAX        10'h3ff
`define TRF_EXT_BIAS       12'h100
`define TRF_SUM_TWOS_MIN   12'hf04
`define TRF_SUM_TWOS_MAX   12'h1ff
`define TRF_SUM_EXT_MIN    12'h004
`define TRF_SUM_EXT_MAX    12'h3ff

`endif

// ---- trf_pkg.sv ----
/*
  Types of the temperature result formatter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package trf_pkg;

  typedef enum logic [1:0] {
    TRF_LIVE   = 2'b01,
    TRF_FROZEN = 2'b10
  } trf_freeze_t;

  typedef logic [9:0] trf_result_t;

endpackage
`default_nettype wire

// ---- trf_formatter.sv ----
/*
  One channel of offset correction, encoding and limit comparison.
  Assumes a 10-bit two's complement raw result in quarter degrees.
*/
`timescale 1ns/1ps
`default_nettype none
`include "trf_map.svh"

module trf_formatter (
  // Measurement
  input  wire logic [9:0]  raw,
  input  wire logic        fault,
  // Settings
  input  wire logic [7:0]  offset,
  input  wire logic        half_step,
  input  wire logic        compat,
  input  wire logic [7:0]  low_limit,
  input  wire logic [7:0]  high_limit,
  // Result
  output trf_pkg::trf_result_t result,
  output logic             over_high,
  output logic             at_low
);

  wire logic signed [11:0] raw_ext;
  wire logic signed [11:0] offset_q;
  wire logic signed [11:0] sum;
  wire logic signed [11:0] ext_sum;
  wire logic [9:0]         twos_val;
  wire logic [9:0]         ext_val;
  wire logic [7:0]         upper;

  assign raw_ext  = {{2{raw[9]}}, raw};
  // Offset in whole or half degree steps, scaled to quarter degrees
  assign offset_q = half_step ? {{3{offset[7]}}, offset, 1'b0}
                              : {{2{offset[7]}}, offset, 2'b00};
  assign sum      = raw_ext + offset_q;
  assign ext_sum  = sum + $signed(`TRF_EXT_BIAS);

  assign twos_val = fault ? `TRF_TWOS_FAULT :
                    (sum < $signed(`TRF_SUM_TWOS_MIN)) ? `TRF_TWOS_MIN :
                    (sum > $signed(`TRF_SUM_TWOS_MAX)) ? `TRF_TWOS_MAX : sum[9:0];
  assign ext_val  = fault ? `TRF_EXT_FAULT :
                    (ext_sum < $signed(`TRF_SUM_EXT_MIN)) ? `TRF_EXT_MIN :
                    (ext_sum > $signed(`TRF_SUM_EXT_MAX)) ? `TRF_EXT_MAX : ext_sum[9:0];

  assign result   = compat ? twos_val : ext_val;
  assign upper    = result[9:2];

  // Window compare on the stored form; signed only in two's complement
  assign over_high = compat ? ($signed(upper) > $signed(high_limit)) : (upper > high_limit);
  assign at_low    = compat ? ($signed(upper) <= $signed(low_limit)) : (upper <= low_limit);

endmodule
`default_nettype wire

// ---- trf_result_formatter_monitor.sv ----
/*
  Port checker of the temperature result formatter.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module trf_result_formatter_monitor (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // Wishbone slave
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Measurements
  input wire logic [9:0]  meas_remote_one,
  input wire logic [9:0]  meas_local,
  input wire logic [9:0]  meas_remote_two,
  input wire logic [2:0]  meas_fault,
  input wire logic [2:0]  meas_valid,
  // Status and alert
  input wire logic [2:0]  temp_high_status,
  input wire logic [2:0]  temp_low_status,
  input wire logic        alert_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_answers_request: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in the next cycle");
  chk_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_read_byte_wide: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  chk_read_data_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data changed outside a read");
  chk_status_needs_result: assert property (meas_valid == 3'b000 |=> $stable(temp_high_status) && $stable(temp_low_status))
    else $error("status changed without a result");
  chk_alert_has_flag: assert property (!alert_n |-> $past(|{temp_high_status, temp_low_status}))
    else $error("alert without a flag");
  chk_alert_clears: assert property ({temp_high_status, temp_low_status} == 6'h0 |=> alert_n)
    else $error("alert stays with no flag");
endmodule
`default_nettype wire

// ---- trf_host.sv ----
/*
  Host model: a classic Wishbone master issuing single cycles.
  Assumes the slave answers with a one-cycle ack.
*/
`timescale 1ns/1ps
`default_nettype none
module trf_host (
  // Clock
  input  wire logic        clk_sys,
  // Wishbone master
  output logic [9:0]       wb_adr_i,
  output logic [31:0]      wb_dat_i,
  output logic [3:0]       wb_sel_i,
  output logic             wb_we_i,
  output logic             wb_cyc_i,
  output logic             wb_stb_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o
);
  initial begin
    wb_adr_i = 10'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
  end

  // One bus cycle; ok is low if no ack came
  task automatic xfer(input logic [7:0] idx, input logic we, input logic [7:0] wd,
                      output logic [7:0] rd, output logic ok);
    int n;
    @(posedge clk_sys);
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, wd};
    wb_sel_i <= 4'hf;
    wb_we_i <= we;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    ok = (wb_ack_o === 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb_trf_result_formatter.sv ----
/*
  Self-checking bench of the temperature result formatter.
  Assumes the host model and the port checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_trf_result_formatter;
  logic        clk_sys;
  logic        reset_n;
  logic [9:0]  wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0]  wb_sel_i;
  logic        wb_we_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [9:0]  raw [3];
  logic [2:0]  meas_fault;
  logic [2:0]  meas_valid;
  logic [2:0]  temp_high_status;
  logic [2:0]  temp_low_status;
  logic        alert_n;
  int          failures;
  int          total_checks;

  trf_result_formatter dut (.clk_sys(clk_sys), .reset_n(reset_n), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .meas_remote_one(raw[0]), .meas_local(raw[1]), .meas_remote_two(raw[2]),
    .meas_fault(meas_fault), .meas_valid(meas_valid), .temp_high_status(temp_high_status),
    .temp_low_status(temp_low_status), .alert_n(alert_n));
  trf_host host (.clk_sys(clk_sys), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic access(input logic [7:0] idx, input logic we, input logic [7:0] wd, output logic [7:0] d);
    logic ok;
    host.xfer(idx, we, wd, d, ok);
    if (!ok) begin
      failures++;
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] d;
    access(idx, 1'b1, v, d);
  endtask

  task automatic reg_is(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    access(idx, 1'b0, 8'h00, d);
    check($sformatf("reg %h", idx), exp, d);
  endtask

  // One result on one channel, then time to publish
  task automatic meas(input int ch, input logic [9:0] r, input logic f);
    @(posedge clk_sys);
    raw[ch] <= r;
    meas_fault[ch] <= f;
    meas_valid[ch] <= 1'b1;
    @(posedge clk_sys);
    meas_valid[ch] <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic s_reset;
    logic [7:0] idx [14] = '{8'h4e, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h70, 8'h71, 8'h72, 8'h00, 8'h77,
                             8'h25, 8'h26, 8'h27};
    logic [7:0] exp [14] = '{8'h81, 8'h7f, 8'h81, 8'h7f, 8'h81, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 14; i++) begin
      reg_is(idx[i], exp[i]);
    end
    check("alert_n", 8'h01, {7'h0, alert_n});
  endtask

  task automatic s_extended;
    meas(0, 10'h029, 1'b0);
    meas(1, 10'h000, 1'b0);
    meas(2, 10'h066, 1'b0);
    reg_is(8'h25, 8'h4a);
    reg_is(8'h26, 8'h40);
    reg_is(8'h27, 8'h59);
    reg_is(8'h77, 8'h84);
    meas(1, 10'h1fc, 1'b0);
    reg_is(8'h26, 8'h40);
    reg_is(8'h25, 8'h4a);
    reg_is(8'h27, 8'h59);
    repeat (2) @(posedge clk_sys);
    reg_is(8'h26, 8'hbf);
    check("high1", 8'h01, {7'h0, temp_high_status[1]});
    meas(1, 10'h000, 1'b1);
    reg_is(8'h26, 8'h00);
    check("low1", 8'h01, {7'h0, temp_low_status[1]});
  endtask

  task automatic s_offset;
    wr(8'h71, 8'h05);
    meas(1, 10'h000, 1'b0);
    reg_is(8'h26, 8'h45);
    wr(8'h7c, 8'h02);
    meas(1, 10'h000, 1'b0);
    reg_is(8'h26, 8'h42);
    wr(8'h7c, 8'h00);
    wr(8'h71, 8'hfb);
    meas(1, 10'h000, 1'b0);
    reg_is(8'h26, 8'h3b);
    wr(8'h72, 8'h01);
    meas(2, 10'h000, 1'b0);
    reg_is(8'h27, 8'h41);
    wr(8'h71, 8'h00);
  endtask

  // A result lands on the very edge of the low-bit read
  task automatic s_freeze_edge;
    logic [7:0] d;
    fork
      meas(0, 10'h0fe, 1'b0);
      begin
        @(posedge clk_sys);
        access(8'h77, 1'b0, 8'h00, d);
      end
    join
    check("low bits", 8'h04, d);
    reg_is(8'h25, 8'h4a);
    reg_is(8'h26, 8'h3b);
    reg_is(8'h27, 8'h41);
    reg_is(8'h25, 8'h7f);
  endtask

  task automatic s_limits;
    wr(8'h51, 8'h45);
    wr(8'h50, 8'h30);
    meas(1, 10'h014, 1'b0);
    check("high1", 8'h00, {7'h0, temp_high_status[1]});
    meas(1, 10'h018, 1'b0);
    check("high1", 8'h01, {7'h0, temp_high_status[1]});
    reg_is(8'h7e, 8'h2a);
    check("alert_n", 8'h01, {7'h0, alert_n});
    wr(8'h7d, 8'h3d);
    reg_is(8'h7d, 8'h3d);
    wr(8'h7c, 8'h04);
    meas(1, 10'h018, 1'b0);
    check("alert_n", 8'h00, {7'h0, alert_n});
    wr(8'h7d, 8'h3f);
    meas(1, 10'h018, 1'b0);
    check("alert_n", 8'h01, {7'h0, alert_n});
    wr(8'h7c, 8'h00);
    meas(1, 10'h3c0, 1'b0);
    check("low1", 8'h01, {7'h0, temp_low_status[1]});
    meas(1, 10'h3c4, 1'b0);
    check("low1", 8'h00, {7'h0, temp_low_status[1]});
  endtask

  task automatic s_compat;
    wr(8'h7c, 8'h01);
    wr(8'h51, 8'h10);
    wr(8'h50, 8'hc9);
    meas(1, 10'h3d8, 1'b0);
    reg_is(8'h26, 8'hf6);
    check("high1", 8'h00, {7'h0, temp_high_status[1]});
    meas(1, 10'h270, 1'b0);
    reg_is(8'h26, 8'hc1);
    check("low1", 8'h01, {7'h0, temp_low_status[1]});
    meas(1, 10'h000, 1'b1);
    reg_is(8'h26, 8'h80);
    wr(8'h26, 8'haa);
    reg_is(8'h26, 8'h80);
  endtask

  initial begin
    reset_n = 1'b0;
    raw = '{10'h0, 10'h0, 10'h0};
    meas_fault = 3'b000;
    meas_valid = 3'b000;
    failures = 0;
    total_checks = 0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    s_reset();
    s_extended();
    s_offset();
    s_freeze_edge();
    s_limits();
    s_compat();
    test_done();
  end
endmodule

bind trf_result_formatter trf_result_formatter_monitor mon (.clk_sys(clk_sys), .reset_n(reset_n),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .meas_remote_one(meas_remote_one),
  .meas_local(meas_local), .meas_remote_two(meas_remote_two), .meas_fault(meas_fault),
  .meas_valid(meas_valid), .temp_high_status(temp_high_status), .temp_low_status(temp_low_status),
  .alert_n(alert_n));
`default_nettype wire
